//--- src/adc_select_pkg.sv
package adc_select_pkg;
   // Register offsets (byte index on the plain register port)
   localparam logic [7:0] ctrl_first_addr = 8'h00;
   localparam logic [7:0] ctrl_second_addr = 8'h01;
   localparam logic [7:0] temp_ctrl_addr = 8'h02;
   localparam logic [7:0] regulator_ctrl_addr = 8'h03;
   localparam logic [7:0] pin_share_low_addr = 8'h04;
   localparam logic [7:0] pin_share_high_addr = 8'h05;
   localparam logic [7:0] port_dir_addr = 8'h06;
   localparam logic [7:0] pull_high_addr = 8'h07;
   localparam logic [7:0] cal_hot_high_addr = 8'h08;
   localparam logic [7:0] cal_hot_low_addr = 8'h09;
   localparam logic [7:0] cal_warm_high_addr = 8'h0a;
   localparam logic [7:0] cal_warm_low_addr = 8'h0b;
   localparam logic [7:0] route_status_addr = 8'h0c;
   // Field positions
   localparam int chan_lsb = 0;
   localparam int chan_msb = 3;
   localparam int refsel_lsb = 3;
   localparam int refsel_msb = 4;
   localparam int insrc_lsb = 5;
   localparam int insrc_msb = 7;
   localparam int temp_en_bit = 0;
   localparam int regout_sw_bit = 0;
   // Reset values, write masks and the zero byte
   localparam logic [7:0] ctrl_first_reset = 8'h00;
   localparam logic [7:0] ctrl_second_reset = 8'h00;
   localparam logic [7:0] temp_ctrl_reset = 8'h02;
   localparam logic [7:0] temp_ctrl_mask = 8'h03;
   localparam logic [7:0] ctrl_first_mask = 8'hef;
   localparam logic [7:0] zero_byte = 8'h00;
   // Encodings
   localparam logic [2:0] insrc_forbidden = 3'h7;
   localparam logic [3:0] chan_float_min = 4'h8;
   // Factory data load: index of the last calibration word
   localparam logic [1:0] cal_words = 2'h3;
   typedef enum {ref_pin_or_reg, ref_supply, ref_temp} ref_kind_type;
   typedef enum {src_external, src_bandgap, src_temp, src_ground,
                 src_none} src_kind_type;
endpackage

//--- src/adc_cal_store.sv
`timescale 1ns/10ps
`default_nettype none
module adc_cal_store
   import adc_select_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Factory nonvolatile data source
   output logic [1:0] nv_addr,
   input wire logic [11:0] nv_data,
   // Stored values
   output logic [11:0] cal_hot,
   output logic [11:0] cal_warm,
   output logic loaded
);
   typedef struct packed {
      logic [1:0] idx;
      logic [11:0] hot;
      logic [11:0] warm;
      logic done;
   } state_type;
   state_type s;
   state_type next_s;
   // Word 1 holds the hot value, word 3 the warm value
   always_comb begin
      next_s = s;
      if (!s.done) begin
         if (s.idx == 2'h1)
            next_s.hot = nv_data; // R17
         if (s.idx == cal_words) begin
            next_s.warm = nv_data; // R17
            next_s.done = 1'b1;
         end else begin
            next_s.idx = s.idx + 2'h1;
         end
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
      end else if (clk_en) begin
         s <= next_s;
      end
   end
   assign nv_addr = s.idx;
   assign cal_hot = s.hot;
   assign cal_warm = s.warm;
   assign loaded = s.done;
endmodule // adc_cal_store
`default_nettype wire

//--- src/adc_pin_share.sv
`timescale 1ns/10ps
`default_nettype none
module adc_pin_share
   import adc_select_pkg::*;
(
   // Pin-share selections and port settings
   input wire logic [7:0] analog_sel,
   input wire logic [7:0] port_dir,
   input wire logic [7:0] pull_high,
   // Effective pin controls
   output logic [7:0] digital_en,
   output logic [7:0] dir_eff,
   output logic [7:0] pull_eff
);
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_pin
         assign digital_en[i] = ~analog_sel[i]; // R9
         assign pull_eff[i] = pull_high[i] & ~analog_sel[i]; // R10
         assign dir_eff[i] = analog_sel[i] | port_dir[i]; // R11
      end
   endgenerate
endmodule // adc_pin_share
`default_nettype wire

//--- src/adc_reference_input_select.sv
// Contract
// [R1] Read-only hot calibration pair: high bits 11..4, low 3..0 then zeros.
// [R2] Read-only warm calibration pair, same layout, low nibble reads zero.
// [R3] Reference select 01 or 11 routes converter analog supply.
// [R4] Reference select 10 uses temp sensor reference; software enables it.
// [R5] Reference select 00 uses external pin or regulator, never both.
// [R6] Software disables other functions of external reference pin.
// [R7] Software sets regulator output switch when regulator is reference.
// [R8] Software keeps pin and regulator off when internal reference chosen.
// [R9] Pin chosen as analog input loses its original function.
// [R10] Pull-high resistor disconnected while pin is an analog input.
// [R11] Analog pin selection overrides port direction register.
// [R12] Source 000, 101, 110 with channel 0..7 picks external channel.
// [R13] External source with channel 8..15 leaves converter input floating.
// [R14] Source 001 bandgap, 010 temp sensor, 011 or 100 ground.
// [R15] Software sets channel 8..15 whenever internal source chosen.
// [R16] Software never writes 111 to input source field.
// [R17] Calibration pairs load from factory data; writes ignored.
// [R18] Input source field is bits 7..5 of second control register.
// [R19] Reference field is bits 4..3 of second control register.
// [R20] Channel field is bits 3..0 of first control register.
`timescale 1ns/10ps
`default_nettype none
module adc_reference_input_select
   import adc_select_pkg::*;
(
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Factory nonvolatile data
   output logic [1:0] nv_addr,
   input wire logic [11:0] nv_data,
   // Reference routing
   output logic ref_use_supply,
   output logic ref_use_temp,
   output logic ref_use_pin,
   output logic ref_use_regulator,
   output logic temp_sensor_enable,
   output logic regulator_output_switch,
   // Input routing
   output logic [7:0] external_channels,
   output logic amplifier_output_path,
   output logic in_bandgap,
   output logic in_temp_sensor,
   output logic in_ground,
   output logic in_floating,
   // Pin controls
   output logic [7:0] pin_digital_en,
   output logic [7:0] pin_dir_eff,
   output logic [7:0] pin_pull_eff,
   output logic vref_pin_other_en
);
   typedef struct packed {
      logic [7:0] ctrl_first;
      logic [7:0] ctrl_second;
      logic [7:0] temp_ctrl;
      logic [7:0] regulator_ctrl;
      logic [7:0] share_low;
      logic [7:0] share_high;
      logic [7:0] port_dir;
      logic [7:0] pull_high;
      logic [7:0] rdata;
      logic ref_supply;
      logic ref_temp;
      logic ref_pin;
      logic ref_reg;
      logic [7:0] chan;
      logic amp;
      logic bg;
      logic ts;
      logic gnd;
      logic flt;
      logic [7:0] dig;
      logic [7:0] dir;
      logic [7:0] pull;
      logic vref_other;
   } state_type;
   state_type s;
   state_type next_s;
   logic [11:0] cal_hot;
   logic [11:0] cal_warm;
   logic cal_loaded;
   logic [7:0] dig_c;
   logic [7:0] dir_c;
   logic [7:0] pull_c;
   logic [2:0] insrc;
   logic [1:0] refsel;
   logic [3:0] chsel;
   logic ext_src;
   src_kind_type src_kind;
   ref_kind_type ref_kind;

   adc_cal_store u_cal (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .nv_addr(nv_addr),
      .nv_data(nv_data),
      .cal_hot(cal_hot),
      .cal_warm(cal_warm),
      .loaded(cal_loaded)
   );

   // Share low selects analog use per pin; share high bit 0 frees vref pin only while ref_pin is set
   adc_pin_share u_share (
      .analog_sel(s.share_low),
      .port_dir(s.port_dir),
      .pull_high(s.pull_high),
      .digital_en(dig_c),
      .dir_eff(dir_c),
      .pull_eff(pull_c)
   );

   assign insrc = s.ctrl_second[insrc_msb:insrc_lsb]; // R18
   assign refsel = s.ctrl_second[refsel_msb:refsel_lsb]; // R19
   assign chsel = s.ctrl_first[chan_msb:chan_lsb]; // R20

   // Decode the input source
   always_comb begin
      ext_src = 1'b0;
      case (insrc)
         3'h0, 3'h5, 3'h6: begin
            ext_src = 1'b1; // R12
            src_kind = src_external;
         end
         3'h1: src_kind = src_bandgap; // R14
         3'h2: src_kind = src_temp; // R14
         3'h3, 3'h4: src_kind = src_ground; // R14
         default: src_kind = src_none;
      endcase
   end

   // Decode the reference
   always_comb begin
      case (refsel)
         2'h0: ref_kind = ref_pin_or_reg; // R5
         2'h2: ref_kind = ref_temp; // R4
         default: ref_kind = ref_supply; // R3
      endcase
   end

   always_comb begin
      next_s = s;
      // Register writes; calibration addresses take no write
      if (reg_write) begin
         if (reg_addr == ctrl_first_addr) begin
            next_s.ctrl_first = reg_wdata & ctrl_first_mask;
         end else if (reg_addr == ctrl_second_addr) begin
            // The forbidden source code keeps the previous source
            if (reg_wdata[insrc_msb:insrc_lsb] == insrc_forbidden) begin // R16
               next_s.ctrl_second[refsel_msb:0] = reg_wdata[refsel_msb:0];
            end else begin
               next_s.ctrl_second = reg_wdata;
            end
         end else if (reg_addr == temp_ctrl_addr) begin
            next_s.temp_ctrl = reg_wdata & temp_ctrl_mask;
         end else if (reg_addr == regulator_ctrl_addr) begin
            next_s.regulator_ctrl = reg_wdata;
         end else if (reg_addr == pin_share_low_addr) begin
            next_s.share_low = reg_wdata;
         end else if (reg_addr == pin_share_high_addr) begin
            next_s.share_high = reg_wdata;
         end else if (reg_addr == port_dir_addr) begin
            next_s.port_dir = reg_wdata;
         end else if (reg_addr == pull_high_addr) begin
            next_s.pull_high = reg_wdata;
         end
      end
      // Register reads, data stand one cycle later
      next_s.rdata = zero_byte;
      if (reg_read) begin
         if (reg_addr == ctrl_first_addr) begin
            next_s.rdata = s.ctrl_first;
         end else if (reg_addr == ctrl_second_addr) begin
            next_s.rdata = s.ctrl_second;
         end else if (reg_addr == temp_ctrl_addr) begin
            next_s.rdata = s.temp_ctrl;
         end else if (reg_addr == regulator_ctrl_addr) begin
            next_s.rdata = s.regulator_ctrl;
         end else if (reg_addr == pin_share_low_addr) begin
            next_s.rdata = s.share_low;
         end else if (reg_addr == pin_share_high_addr) begin
            next_s.rdata = s.share_high;
         end else if (reg_addr == port_dir_addr) begin
            next_s.rdata = s.port_dir;
         end else if (reg_addr == pull_high_addr) begin
            next_s.rdata = s.pull_high;
         end else if (reg_addr == cal_hot_high_addr) begin
            next_s.rdata = cal_hot[11:4]; // R1
         end else if (reg_addr == cal_hot_low_addr) begin
            next_s.rdata = {cal_hot[3:0], 4'h0}; // R1
         end else if (reg_addr == cal_warm_high_addr) begin
            next_s.rdata = cal_warm[11:4]; // R2
         end else if (reg_addr == cal_warm_low_addr) begin
            next_s.rdata = {cal_warm[3:0], 4'h0}; // R2
         end else if (reg_addr == route_status_addr) begin
            next_s.rdata = {cal_loaded, s.flt, s.gnd, s.ts, s.bg,
                            s.ref_reg | s.ref_pin, s.ref_temp,
                            s.ref_supply};
         end
      end
      // Reference routing
      next_s.ref_supply = (ref_kind == ref_supply); // R3
      next_s.ref_temp = (ref_kind == ref_temp); // R4
      // Regulator wins when its switch is set, so both never join
      next_s.ref_reg = (ref_kind == ref_pin_or_reg) &&
                       s.regulator_ctrl[regout_sw_bit]; // R5
      next_s.ref_pin = (ref_kind == ref_pin_or_reg) &&
                       !s.regulator_ctrl[regout_sw_bit]; // R5
      // Input routing
      next_s.chan = '0;
      next_s.amp = 1'b0;
      next_s.flt = 1'b0;
      if (ext_src) begin
         if (chsel < chan_float_min) begin
            next_s.chan[chsel[2:0]] = 1'b1; // R12
            next_s.amp = 1'b1; // R12
         end else begin
            next_s.flt = 1'b1; // R13
         end
      end
      next_s.bg = (src_kind == src_bandgap); // R14
      next_s.ts = (src_kind == src_temp); // R14
      next_s.gnd = (src_kind == src_ground); // R14
      next_s.dig = dig_c; // R9
      next_s.dir = dir_c; // R11
      next_s.pull = pull_c; // R10
      next_s.vref_other = !(next_s.ref_pin && s.share_high[0]);
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.ctrl_first <= ctrl_first_reset;
         s.ctrl_second <= ctrl_second_reset;
         s.temp_ctrl <= temp_ctrl_reset;
         s.dig <= 8'hff;
         s.vref_other <= 1'b1;
         s.ref_pin <= 1'b1;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign ref_use_supply = s.ref_supply;
   assign ref_use_temp = s.ref_temp;
   assign ref_use_pin = s.ref_pin;
   assign ref_use_regulator = s.ref_reg;
   assign temp_sensor_enable = s.temp_ctrl[temp_en_bit];
   assign regulator_output_switch = s.regulator_ctrl[regout_sw_bit];
   assign external_channels = s.chan;
   assign amplifier_output_path = s.amp;
   assign in_bandgap = s.bg;
   assign in_temp_sensor = s.ts;
   assign in_ground = s.gnd;
   assign in_floating = s.flt;
   assign pin_digital_en = s.dig;
   assign pin_dir_eff = s.dir;
   assign pin_pull_eff = s.pull;
   assign vref_pin_other_en = s.vref_other;
endmodule // adc_reference_input_select
`default_nettype wire

//--- verification/adc_select_properties.sv
`timescale 1ns/10ps
`default_nettype none
module adc_select_properties
   import adc_select_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // Routing
   input wire logic ref_use_supply,
   input wire logic ref_use_temp,
   input wire logic ref_use_pin,
   input wire logic ref_use_regulator,
   input wire logic [7:0] external_channels,
   input wire logic amplifier_output_path,
   input wire logic in_bandgap,
   input wire logic in_temp_sensor,
   input wire logic in_ground,
   input wire logic in_floating,
   // Pin controls
   input wire logic [7:0] pin_digital_en,
   input wire logic [7:0] pin_dir_eff,
   input wire logic [7:0] pin_pull_eff
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   wire logic wr_en = clk_en && reg_write;
   wire logic wr_second = wr_en && reg_addr == ctrl_second_addr;
   wire logic wr_share = wr_en && reg_addr == pin_share_low_addr;
   sequence wr_ref(logic [1:0] r);
      wr_second && reg_wdata[4:3] == r;
   endsequence
   sequence rd_at(logic [7:0] a);
      clk_en && reg_read && reg_addr == a;
   endsequence
   a_hot_nibble:
      assert property (rd_at(cal_hot_low_addr) |=> reg_rdata[3:0] == 4'h0)
      else $error("hot low nibble not zero");
   a_warm_nibble:
      assert property (rd_at(cal_warm_low_addr) |=> reg_rdata[3:0] == 4'h0)
      else $error("warm low nibble not zero");
   a_ref_supply:
      assert property (wr_ref(2'h1) or wr_ref(2'h3) |-> ##2 ref_use_supply)
      else $error("supply reference not routed");
   a_ref_temp:
      assert property (wr_ref(2'h2) |-> ##2 ref_use_temp)
      else $error("sensor reference not routed");
   a_ref_single:
      assert property ($onehot({ref_use_supply, ref_use_temp, ref_use_pin,
         ref_use_regulator})) else $error("reference route not one-hot");
   a_share_digital:
      assert property (wr_share |-> ##2
         pin_digital_en == ~$past(reg_wdata, 2))
      else $error("digital enable wrong");
   a_pull_removed:
      assert property (wr_share |-> ##2
         (pin_pull_eff & $past(reg_wdata, 2)) == 0)
      else $error("pull-high kept on analog pin");
   a_dir_override:
      assert property (wr_share |-> ##2
         (~pin_dir_eff & $past(reg_wdata, 2)) == 0)
      else $error("direction not overridden");
   a_input_single:
      assert property ($past(reset_n) |-> $onehot({|external_channels,
         in_bandgap, in_temp_sensor, in_ground, in_floating})
         && $onehot0(external_channels)
         && amplifier_output_path == |external_channels)
      else $error("input route not single");
   a_src_bandgap:
      assert property (wr_second && reg_wdata[7:5] == 3'h1 |-> ##2 in_bandgap)
      else $error("bandgap not routed");
endmodule // adc_select_properties
bind adc_reference_input_select
   adc_select_properties adc_select_properties_i (.*);
`default_nettype wire

//--- verification/adc_nv_model.sv
`timescale 1ns/10ps
`default_nettype none
module adc_nv_model #(
   parameter logic [11:0] hot_value = 12'h9c5,
   parameter logic [11:0] warm_value = 12'h6a3
) (
   // Factory data word
   input wire logic [1:0] nv_addr,
   output logic [11:0] nv_data
);
   // Spare words differ per index so a wrong fetch shows
   always_comb begin
      case (nv_addr)
         2'h1: nv_data = hot_value;
         2'h3: nv_data = warm_value;
         default: nv_data = ~{6{nv_addr}};
      endcase
   end
endmodule // adc_nv_model
`default_nettype wire

//--- verification/adc_reference_input_select_tb.sv
`timescale 1ns/10ps
`default_nettype none
module adc_reference_input_select_tb
   import adc_select_pkg::*;
();
   localparam logic [11:0] hot = 12'h9c5;
   localparam logic [11:0] warm = 12'h6a3;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata, external_channels, pin_digital_en;
   logic [7:0] pin_dir_eff, pin_pull_eff;
   logic [1:0] nv_addr;
   logic [11:0] nv_data;
   logic ref_use_supply, ref_use_temp, ref_use_pin, ref_use_regulator;
   logic temp_sensor_enable, regulator_output_switch, amplifier_output_path;
   logic in_bandgap, in_temp_sensor, in_ground, in_floating, vref_pin_other_en;
   int n_errors = 0;
   int compares = 0;
   wire logic [7:0] ref_bits = {4'h0, ref_use_supply, ref_use_temp,
      ref_use_pin, ref_use_regulator};
   wire logic [7:0] in_bits = {3'h0, in_bandgap, in_temp_sensor, in_ground,
      in_floating, amplifier_output_path};
   always #20 core_clk = ~core_clk;
   adc_reference_input_select adc_reference_input_select_i (.*);
   adc_nv_model #(.hot_value(hot), .warm_value(warm)) adc_nv_model_i (
      .nv_addr(nv_addr), .nv_data(nv_data));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic settle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   task automatic stop_test();
      $display("n_errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      logic [7:0] e;
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      rd(temp_ctrl_addr, 8'h02);
      rd(route_status_addr, 8'h84);
      rd(cal_hot_high_addr, hot[11:4]);
      rd(cal_hot_low_addr, {hot[3:0], 4'h0});
      rd(cal_warm_high_addr, warm[11:4]);
      rd(cal_warm_low_addr, {warm[3:0], 4'h0});
      wr(cal_hot_high_addr, 8'hff);
      wr(cal_warm_low_addr, 8'hff);
      rd(cal_hot_high_addr, hot[11:4]);
      rd(cal_warm_low_addr, {warm[3:0], 4'h0});
      rd(8'h40, 8'h00);
      wr(ctrl_first_addr, 8'hff);
      rd(ctrl_first_addr, 8'hef);
      wr(ctrl_first_addr, 8'h08);
      wr(temp_ctrl_addr, 8'h03);
      for (int r = 3; r >= 0; r--) begin
         wr(ctrl_second_addr, {3'h0, r[1:0], 3'h0});
         rd(ctrl_second_addr, {3'h0, r[1:0], 3'h0});
         e = r == 0 ? 8'h02 : r == 2 ? 8'h04 : 8'h08;
         chk(ref_bits, e);
      end
      chk({7'h0, temp_sensor_enable}, 8'h01);
      wr(pin_share_high_addr, 8'h01);
      settle();
      chk({7'h0, vref_pin_other_en}, 8'h00);
      wr(pin_share_high_addr, 8'h00);
      wr(regulator_ctrl_addr, 8'h01);
      settle();
      chk(ref_bits, 8'h01);
      chk({7'h0, regulator_output_switch}, 8'h01);
      wr(regulator_ctrl_addr, 8'h00);
      for (int s = 0; s < 7; s++) begin
         for (int c = 0; c < 9; c++) begin
            if (s inside {[1:4]} && c < 8) continue;
            wr(ctrl_second_addr, {s[2:0], 5'h0});
            wr(ctrl_first_addr, c[7:0]);
            rd(ctrl_second_addr, {s[2:0], 5'h0});
            settle();
            chk(external_channels, 8'h01 << c);
            e = s == 1 ? 8'h10 : s == 2 ? 8'h08 : s inside {3, 4} ? 8'h04
               : c == 8 ? 8'h02 : 8'h01;
            chk(in_bits, e);
         end
      end
      wr(ctrl_second_addr, 8'hf8);
      rd(ctrl_second_addr, 8'hd8);
      wr(port_dir_addr, 8'h00);
      wr(pull_high_addr, 8'hff);
      wr(pin_share_low_addr, 8'h0f);
      settle();
      chk(pin_digital_en, 8'hf0);
      chk(pin_pull_eff, 8'hf0);
      chk(pin_dir_eff, 8'h0f);
      // A write while the clock enable is low must not land
      @(posedge core_clk);
      clk_en <= 1'b0;
      wr(pull_high_addr, 8'h00);
      clk_en <= 1'b1;
      rd(pull_high_addr, 8'hff);
      chk(pin_pull_eff, 8'hf0);
      stop_test();
   end
   initial begin
      repeat (4000) @(posedge core_clk);
      n_errors++;
      stop_test();
   end
endmodule // adc_reference_input_select_tb
`default_nettype wire
